// >>> inc/srm_pkg.sv
// srm_pkg: constants and types of the standby ram module
// Operation
// - 2-Kbyte array on any 2-Kbyte boundary
// - byte, word and long-word array accesses
// - byte/aligned word one cycle, others two
// - 8-byte block, holes read zero
// - base writes only stopped and unlocked
// - lock sets once, sticks until reset
// - space bit 0 selects program-only
// - space upper bit has no effect
// - no new array access or write on standby supply
// - reset: stop, program space, clear base, unlock
// - reset finishes byte or aligned word access
// - reset in long first word drops second
// - reset in long second word completes
package srm_pkg;

	// ************************************************
	// geometry
	// ************************************************
	localparam int unsigned ADDR_W   = 24; // bus address width
	localparam int unsigned OFS_W    = 11; // byte offset in 2 KB
	localparam int unsigned WORD_AW  = 10; // address bits of the 16-bit words in array
	localparam int unsigned ARR_WDS  = 1024;
	localparam int unsigned REG_W    = 16; // control register width

	// ************************************************
	// control block map (register index = addr[2:1])
	// ************************************************
	localparam logic [1:0] IDX_CFG = 2'h0;
	localparam logic [1:0] IDX_TST = 2'h1;
	localparam logic [1:0] IDX_BAH = 2'h2;
	localparam logic [1:0] IDX_BAL = 2'h3;
	localparam logic [23:0] CTRL_BASE = 24'hfffb40;

	// config fields
	localparam int unsigned CFG_STOP  = 15;
	localparam int unsigned CFG_LOCK  = 12;
	localparam int unsigned CFG_SP_HI = 9;
	localparam int unsigned CFG_SP_LO = 8;
	localparam int unsigned CFG_STBY  = 0;
	localparam logic [1:0] SPACE_RST  = 2'h1;

	// base register fields
	localparam int unsigned BAH_W  = 8;  // addr[23:16]
	localparam int unsigned BAL_LO = 11; // addr[15:11] in [15:11]

	// ************************************************
	// types
	// ************************************************
	typedef enum logic [1:0] {
		SRM_SZ_BYTE,
		SRM_SZ_WORD,
		SRM_SZ_LONG
	} srm_size_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;  // byte address
		srm_size_t         size;  // access size
		logic              write; // 1 = write
		logic              prog;  // 1 = program space
		logic [31:0]       wdata; // right-justified data
	} srm_acc_t;

	typedef struct packed {
		logic        ack;   // access finished
		logic        miss;  // access not claimed
		logic        trunc; // long or odd word cut after first word
		logic [31:0] rdata; // right-justified data
	} srm_resp_t;

endpackage

// >>> design/srm_array.sv
// srm_array: 2 KB storage as two byte lanes of 16-bit words
module srm_array import srm_pkg::*; (
	input  wire logic               core_clk,
	input  wire logic [WORD_AW-1:0] word_addr,
	input  wire logic [1:0]         lane_we,
	input  wire logic [15:0]        wdata,
	output logic [15:0]             rdata
);

	// lane 1 is the even (high) byte
	for (genvar g = 0; g < 2; g++) begin : g_lane
		logic [7:0] mem [ARR_WDS]; // no reset, contents kept

		// write port
		always_ff @(posedge core_clk) begin
			if (lane_we[g]) begin
				mem[word_addr] <= wdata[g*8 +: 8];
			end
		end

		// read is combinational so the op cycle sees it
		assign rdata[g*8 +: 8] = mem[word_addr];
	end

endmodule

// >>> design/srm_top.sv
// srm_top: standby ram module, control block and array access
//
// Added by the designer: the placing of the registers and the strobed register port.
module srm_top import srm_pkg::*; (
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	input  wire logic             soft_rst,
	input  wire logic             standby_supply,
	input  wire logic [2:0]       reg_addr,
	input  wire logic [REG_W-1:0] reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output logic [REG_W-1:0]      reg_rdata,
	input  wire logic             acc_req,
	input  wire srm_acc_t         acc,
	output srm_resp_t             resp
);

	// ************************************************
	// declarations
	// ************************************************
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_C1,
		ST_GAP,
		ST_C2
	} srm_state_t;

	srm_state_t        state_reg;     // access sequencer
	srm_state_t        state_next;
	srm_acc_t          cur_reg;       // access in flight
	logic              two_reg;       // two bus cycles
	logic              rst_pend_reg;  // soft reset waiting
	logic              stop_reg;      // low-power stop
	logic              lock_reg;      // base lock
	logic [1:0]        space_reg;     // space type field
	logic [BAH_W-1:0]  bah_reg;       // base addr[23:16]
	logic [4:0]        bal_reg;       // base addr[15:11]
	logic [REG_W-1:0]  reg_rdata_reg;
	logic              ack_reg;
	logic              miss_reg;
	logic              trunc_reg;
	logic [31:0]       rdata_reg;

	logic [1:0]        idx;           // register index
	logic              apply_rst;     // soft reset takes effect
	logic              rst_now;       // reset seen this cycle
	logic              in_array;
	logic              in_ctrl;
	logic              space_ok;
	logic              hit;
	logic              take;
	logic              req_two;
	logic              base_wr_ok;
	logic              op_act;
	logic              second;
	logic              byte_op;
	logic [OFS_W-1:0]  op_ofs;
	logic [OFS_W-1:0]  step;
	logic [1:0]        lane_we;
	logic [15:0]       mem_wdata;
	logic [15:0]       mem_rdata;
	logic [7:0]        rd_byte;

	assign idx       = reg_addr[2:1];
	assign rst_now   = rst_pend_reg | soft_rst;
	assign apply_rst = rst_pend_reg & (state_reg == ST_IDLE);

	// ************************************************
	// array decode
	// ************************************************
	// base compare on bits above the 2 KB offset
	assign in_array = (acc.addr[ADDR_W-1:OFS_W] == {bah_reg, bal_reg});
	// the block shadows the array if both overlap
	assign in_ctrl  = (acc.addr[ADDR_W-1:3] == CTRL_BASE[ADDR_W-1:3]);
	// only the low bit matters, all cycles are supervisor
	assign space_ok = ~space_reg[0] | acc.prog;
	assign hit      = in_array & space_ok & ~in_ctrl
		& ~stop_reg & ~standby_supply;
	// hold off new accesses while a reset is pending
	assign take     = (state_reg == ST_IDLE) & acc_req & hit & ~rst_now;
	// long or odd word needs a second bus cycle
	assign req_two  = (acc.size == SRM_SZ_LONG)
		| ((acc.size == SRM_SZ_WORD) & acc.addr[0]);

	// ************************************************
	// sequencer
	// ************************************************
	// next state of the bus-cycle walk
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (take) begin
					state_next = ST_C1;
				end
			end
			ST_C1: begin
				// reset in first word drops the second
				if (two_reg && !rst_now) begin
					state_next = ST_GAP;
				end else begin
					state_next = ST_IDLE;
				end
			end
			ST_GAP: begin
				state_next = ST_C2;
			end
			ST_C2: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// capture of the request
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cur_reg <= '0;
			two_reg <= 1'b0;
		end else if (take) begin
			cur_reg <= acc;
			two_reg <= req_two;
		end
	end

	// soft reset waits for the access to end
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rst_pend_reg <= 1'b0;
		end else if (soft_rst) begin
			rst_pend_reg <= 1'b1; // set wins over apply
		end else if (apply_rst) begin
			rst_pend_reg <= 1'b0;
		end
	end

	// ************************************************
	// per bus cycle array operation
	// ************************************************
	assign op_act = (state_reg == ST_C1) | (state_reg == ST_C2);
	assign second = (state_reg == ST_C2);
	assign byte_op = (cur_reg.size == SRM_SZ_BYTE)
		| ((cur_reg.size == SRM_SZ_WORD) & cur_reg.addr[0]);

	// offset, lanes and data of the current bus cycle
	always_comb begin
		// long moves a word, odd word moves a byte
		step = (cur_reg.size == SRM_SZ_LONG) ? OFS_W'(2) : OFS_W'(1);
		op_ofs = cur_reg.addr[OFS_W-1:0];
		if (second) begin
			op_ofs = cur_reg.addr[OFS_W-1:0] + step; // wraps in array
		end
		lane_we = 2'h0;
		mem_wdata = 16'h0;
		if (byte_op) begin
			// even byte in the high lane
			if (cur_reg.size == SRM_SZ_BYTE || second) begin
				mem_wdata = {cur_reg.wdata[7:0], cur_reg.wdata[7:0]};
			end else begin
				mem_wdata = {cur_reg.wdata[15:8], cur_reg.wdata[15:8]};
			end
			lane_we = op_ofs[0] ? 2'h1 : 2'h2;
		end else begin
			if (cur_reg.size == SRM_SZ_LONG && !second) begin
				mem_wdata = cur_reg.wdata[31:16];
			end else begin
				mem_wdata = cur_reg.wdata[15:0];
			end
			lane_we = 2'h3;
		end
		// standby blocks writes even mid access
		if (!(op_act && cur_reg.write && !standby_supply)) begin
			lane_we = 2'h0;
		end
	end

	assign rd_byte = op_ofs[0] ? mem_rdata[7:0] : mem_rdata[15:8];

	// storage
	srm_array u_array (
		.core_clk  (core_clk),
		.word_addr (op_ofs[OFS_W-1:1]),
		.lane_we   (lane_we),
		.wdata     (mem_wdata),
		.rdata     (mem_rdata)
	);

	// ************************************************
	// answer to the array master
	// ************************************************
	// read data assembled over one or two cycles
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_reg <= 32'h0;
		end else if (op_act) begin
			unique case (cur_reg.size)
				SRM_SZ_BYTE: begin
					rdata_reg <= {24'h0, rd_byte};
				end
				SRM_SZ_WORD: begin
					if (!cur_reg.addr[0]) begin
						rdata_reg <= {16'h0, mem_rdata};
					end else if (!second) begin
						rdata_reg <= {16'h0, rd_byte, 8'h0};
					end else begin
						rdata_reg[7:0] <= rd_byte;
					end
				end
				SRM_SZ_LONG: begin
					if (!second) begin
						rdata_reg <= {mem_rdata, 16'h0};
					end else begin
						rdata_reg[15:0] <= mem_rdata;
					end
				end
				default: begin
					rdata_reg <= 32'h0; // illegal size code
				end
			endcase
		end
	end

	// done pulse, one cycle after the last op
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ack_reg   <= 1'b0;
			trunc_reg <= 1'b0;
		end else begin
			ack_reg   <= ((state_reg == ST_C1) && !(two_reg && !rst_now))
				|| (state_reg == ST_C2);
			trunc_reg <= (state_reg == ST_C1) && two_reg && rst_now;
		end
	end

	// unclaimed access flagged so the master moves on
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			miss_reg <= 1'b0;
		end else begin
			miss_reg <= (state_reg == ST_IDLE) && acc_req && !take;
		end
	end

	assign resp = '{ack: ack_reg, miss: miss_reg, trunc: trunc_reg,
		rdata: rdata_reg};

	// ************************************************
	// control registers
	// ************************************************
	assign base_wr_ok = stop_reg & ~lock_reg;

	// config: stop and space
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stop_reg  <= 1'b1;
			space_reg <= SPACE_RST;
		end else if (apply_rst) begin
			stop_reg  <= 1'b1;
			space_reg <= SPACE_RST;
		end else if (reg_wr && idx == IDX_CFG) begin
			// registers stay live while stopped
			stop_reg  <= reg_wdata[CFG_STOP];
			space_reg <= reg_wdata[CFG_SP_HI:CFG_SP_LO];
		end
	end

	// lock: one write to one, then frozen
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lock_reg <= 1'b0;
		end else if (apply_rst) begin
			lock_reg <= 1'b0;
		end else if (reg_wr && idx == IDX_CFG && reg_wdata[CFG_LOCK]) begin
			lock_reg <= 1'b1;
		end
	end

	// base address, guarded against accidental remap
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			bah_reg <= '0;
			bal_reg <= '0;
		end else if (apply_rst) begin
			bah_reg <= '0;
			bal_reg <= '0;
		end else if (reg_wr && base_wr_ok) begin
			if (idx == IDX_BAH) begin
				bah_reg <= reg_wdata[BAH_W-1:0];
			end
			if (idx == IDX_BAL) begin
				bal_reg <= reg_wdata[REG_W-1:BAL_LO];
			end
		end
	end

	// read data stand one cycle, zero otherwise
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata_reg <= '0;
		end else if (reg_rd) begin
			reg_rdata_reg <= '0; // test reg and holes read zero
			unique case (idx)
				IDX_CFG: begin
					reg_rdata_reg[CFG_STOP] <= stop_reg;
					reg_rdata_reg[CFG_LOCK] <= lock_reg;
					reg_rdata_reg[CFG_SP_HI:CFG_SP_LO] <= space_reg;
					reg_rdata_reg[CFG_STBY] <= standby_supply;
				end
				IDX_TST: begin
					reg_rdata_reg <= '0;
				end
				IDX_BAH: begin
					reg_rdata_reg[BAH_W-1:0] <= bah_reg;
				end
				IDX_BAL: begin
					reg_rdata_reg[REG_W-1:BAL_LO] <= bal_reg;
				end
			endcase
		end else begin
			reg_rdata_reg <= '0;
		end
	end

	assign reg_rdata = reg_rdata_reg;

	// ************************************************
	// assertions
	// ************************************************
	miss_timing_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(state_reg == ST_IDLE && acc_req && !hit) |-> ##1 (miss_reg && !ack_reg))
		else $error("unclaimed access not flagged");

	short_ack_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(take && !req_two) |-> ##1 !ack_reg ##1 (ack_reg && !trunc_reg))
		else $error("short access not done in two clocks");

	long_ack_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(take && req_two) ##1 !soft_rst |-> !ack_reg[*3] ##1 ack_reg)
		else $error("two-cycle access not done in four clocks");

	trunc_first_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(take && req_two) ##1 soft_rst |-> ##1 (ack_reg && trunc_reg)
			##1 (state_reg == ST_IDLE))
		else $error("second word not dropped on reset");

	second_word_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(state_reg == ST_GAP && soft_rst) |-> ##2 (ack_reg && !trunc_reg))
		else $error("long access cut in second word");

	byte_finish_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(state_reg == ST_C1 && !two_reg && soft_rst)
			|=> (ack_reg && !trunc_reg && rst_pend_reg))
		else $error("short access not finished before reset");

	reset_values_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		apply_rst |=> (stop_reg && !lock_reg && bah_reg == '0
			&& bal_reg == '0 && space_reg == SPACE_RST))
		else $error("soft reset left wrong state");

	base_guard_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(reg_wr && !apply_rst && !base_wr_ok)
			|=> ($stable(bah_reg) && $stable(bal_reg)))
		else $error("base changed while guarded");

	lock_sticky_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(lock_reg && !apply_rst) |=> lock_reg)
		else $error("lock cleared without reset");

	stop_silent_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(state_reg == ST_IDLE && acc_req && (stop_reg || standby_supply))
			|=> (miss_reg && !ack_reg && state_reg == ST_IDLE))
		else $error("array claimed while stopped or on standby");

	hole_zero_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(reg_rd && idx == IDX_TST) |=> (reg_rdata == '0))
		else $error("unimplemented register not zero");

endmodule

// >>> verification/srm_cpu_model.sv
// srm_cpu_model: processor-side bus master issuing array accesses to the module
module srm_cpu_model import srm_pkg::*; (
	input  wire logic      core_clk,
	input  wire srm_resp_t resp,
	output logic           acc_req,
	output srm_acc_t       acc
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle bus at time zero
	initial begin
		acc_req = 1'b0;
		acc     = '0;
	end

	// ************************************************
	// one access: idle gap, one-cycle request, bounded wait
	// ************************************************
	// lat counts clocks from the request cycle; 8'hff means no answer came
	task automatic access(input srm_acc_t a, input int gap, output srm_resp_t r,
		output logic [7:0] lat);
		int n;
		repeat (gap) @(posedge core_clk);
		@(posedge core_clk);
		acc_req <= 1'b1;
		acc     <= a;
		@(posedge core_clk);
		acc_req <= 1'b0;
		// released fields show garbage so nothing leans on stale values
		acc     <= ~a;
		lat = 8'hff;
		r   = '0;
		for (n = 0; n < 12; n++) begin
			#1;
			if (resp.ack || resp.miss) begin
				r   = resp;
				lat = 8'(n + 1);
				break;
			end
			@(posedge core_clk);
		end
	endtask
endmodule

// >>> verification/srm_top_tb.sv
// srm_top_tb: register and array access regression for the standby ram module
module srm_top_tb import srm_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	// ************************************************
	// signals and counters
	// ************************************************
	logic             core_clk;
	logic             sys_rst;
	logic             soft_rst;
	logic             standby_supply;
	logic [2:0]       reg_addr;
	logic [REG_W-1:0] reg_wdata;
	logic             reg_wr;
	logic             reg_rd;
	logic [REG_W-1:0] reg_rdata;
	logic             acc_req;
	srm_acc_t         acc;
	srm_resp_t        resp;
	int               err_count;
	int               tests_run;
	// 2 KB multiple, clear of the control block and the unreachable range
	localparam logic [23:0] BASE = 24'h123800;

	srm_top i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .soft_rst(soft_rst),
		.standby_supply(standby_supply), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc_req(acc_req),
		.acc(acc), .resp(resp));
	srm_cpu_model i_cpu (.core_clk(core_clk), .resp(resp), .acc_req(acc_req), .acc(acc));

	// 125 MHz clock
	always #4 core_clk = ~core_clk;

	// ************************************************
	// helpers
	// ************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one-cycle write strobe
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, input logic [15:0] exp);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk({16'h0, reg_rdata}, {16'h0, exp});
	endtask

	// array access with expected claim, latency and read data
	task automatic arr(input logic [23:0] a, input srm_size_t sz, input logic w,
		input logic p, input logic [31:0] wd, input logic hit, input logic [31:0] exp);
		srm_resp_t  r;
		logic [7:0] lat;
		logic [7:0] want;
		// two clocks for byte or even word, two bus cycles otherwise
		want = !hit ? 8'h1 : (sz == SRM_SZ_BYTE || (sz == SRM_SZ_WORD && !a[0])) ? 8'h2 : 8'h4;
		i_cpu.access('{addr: a, size: sz, write: w, prog: p, wdata: wd}, 0, r, lat);
		// a lost answer is a mismatch and ends the run
		if (lat == 8'hff) begin
			err_count++;
			results();
		end
		chk({22'h0, r.ack, r.miss, lat}, {22'h0, hit, !hit, want});
		if (hit && !w)
			chk(r.rdata, exp);
	endtask

	// write access cut by a soft reset pulse sampled k-1 edges after taking
	task automatic cut(input srm_size_t sz, input int k, input logic [31:0] wd,
		input logic [7:0] want, input logic tr);
		srm_resp_t  r;
		logic [7:0] lat;
		fork
			i_cpu.access('{addr: BASE + 24'h10, size: sz, write: 1'b1, prog: 1'b1,
				wdata: wd}, 0, r, lat);
			begin
				repeat (k) @(posedge core_clk);
				soft_rst <= 1'b1;
				@(posedge core_clk);
				soft_rst <= 1'b0;
			end
		join
		if (lat == 8'hff) begin
			err_count++;
			results();
		end
		chk({22'h0, r.ack, r.trunc, lat}, {22'h0, 1'b1, tr, want});
		// reset lands once the sequencer goes idle
		repeat (3) @(posedge core_clk);
		rd(3'h0, 16'h8100);
		rd(3'h4, 16'h0000);
		wr(3'h4, {8'h0, BASE[23:16]});
		wr(3'h6, BASE[15:0]);
		wr(3'h0, 16'h0000);
	endtask

	// verdict and end of run
	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ************************************************
	// main sequence
	// ************************************************
	initial begin
		core_clk = 1'b0;
		sys_rst = 1'b1;
		soft_rst = 1'b0;
		standby_supply = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		err_count = 0;
		tests_run = 0;
		repeat (8) @(posedge core_clk);
		sys_rst <= 1'b0;
		// reset values, test register and holes
		rd(3'h0, 16'h8100);
		rd(3'h4, 16'h0000);
		rd(3'h6, 16'h0000);
		wr(3'h2, 16'hffff);
		rd(3'h2, 16'h0000);
		$display("reset state done");
		// stopped: array silent, base still writable
		arr(24'h000010, SRM_SZ_BYTE, 1'b0, 1'b1, '0, 1'b0, '0);
		wr(3'h4, {8'h0, BASE[23:16]});
		wr(3'h6, BASE[15:0] | 16'h00ff);
		rd(3'h4, {8'h0, BASE[23:16]});
		rd(3'h6, BASE[15:0]);
		// lock once set blocks base writes and cannot clear
		wr(3'h0, 16'h9000);
		wr(3'h4, 16'h0055);
		rd(3'h4, {8'h0, BASE[23:16]});
		wr(3'h0, 16'h8000);
		rd(3'h0, 16'h9000);
		wr(3'h0, 16'h0000);
		rd(3'h0, 16'h1000);
		$display("mapping done");
		// sizes, latency, big-endian lanes
		arr(BASE + 24'h1, SRM_SZ_BYTE, 1'b1, 1'b0, 32'h5a, 1'b1, '0);
		arr(BASE + 24'h1, SRM_SZ_BYTE, 1'b0, 1'b0, '0, 1'b1, 32'h5a);
		arr(BASE + 24'h4, SRM_SZ_LONG, 1'b1, 1'b0, 32'ha1b2c3d4, 1'b1, '0);
		arr(BASE + 24'h4, SRM_SZ_LONG, 1'b0, 1'b0, '0, 1'b1, 32'ha1b2c3d4);
		arr(BASE + 24'h5, SRM_SZ_WORD, 1'b0, 1'b0, '0, 1'b1, 32'hb2c3);
		arr(BASE + 24'h6, SRM_SZ_WORD, 1'b0, 1'b0, '0, 1'b1, 32'hc3d4);
		arr(BASE + 24'h7ff, SRM_SZ_BYTE, 1'b1, 1'b1, 32'h3c, 1'b1, '0);
		arr(BASE + 24'h7ff, SRM_SZ_BYTE, 1'b0, 1'b1, '0, 1'b1, 32'h3c);
		arr(BASE + 24'h800, SRM_SZ_BYTE, 1'b0, 1'b1, '0, 1'b0, '0);
		arr(CTRL_BASE, SRM_SZ_WORD, 1'b0, 1'b1, '0, 1'b0, '0);
		$display("access done");
		// every space code, data and program accesses
		for (int s = 0; s < 4; s++) begin
			wr(3'h0, {6'h0, s[1:0], 8'h00});
			arr(BASE + 24'h1, SRM_SZ_BYTE, 1'b0, 1'b0, '0, ~s[0], 32'h5a);
			arr(BASE + 24'h1, SRM_SZ_BYTE, 1'b0, 1'b1, '0, 1'b1, 32'h5a);
		end
		$display("space done");
		// standby supply refuses the array
		@(posedge core_clk);
		standby_supply <= 1'b1;
		arr(BASE + 24'h1, SRM_SZ_BYTE, 1'b0, 1'b1, '0, 1'b0, '0);
		rd(3'h0, 16'h1301);
		@(posedge core_clk);
		standby_supply <= 1'b0;
		$display("standby done");
		// stop again: array silent, registers live
		wr(3'h0, 16'h8000);
		arr(BASE + 24'h1, SRM_SZ_BYTE, 1'b0, 1'b1, '0, 1'b0, '0);
		rd(3'h6, BASE[15:0]);
		wr(3'h0, 16'h0000);
		$display("stop done");
		// soft reset in flight
		arr(BASE + 24'h10, SRM_SZ_LONG, 1'b1, 1'b1, 32'h0, 1'b1, '0);
		cut(SRM_SZ_LONG, 2, 32'hdeadbeef, 8'h2, 1'b1);
		arr(BASE + 24'h10, SRM_SZ_LONG, 1'b0, 1'b1, '0, 1'b1, 32'hdead0000);
		cut(SRM_SZ_LONG, 4, 32'h12345678, 8'h4, 1'b0);
		arr(BASE + 24'h10, SRM_SZ_LONG, 1'b0, 1'b1, '0, 1'b1, 32'h12345678);
		cut(SRM_SZ_LONG, 3, 32'h0f1e2d3c, 8'h4, 1'b0);
		arr(BASE + 24'h10, SRM_SZ_LONG, 1'b0, 1'b1, '0, 1'b1, 32'h0f1e2d3c);
		cut(SRM_SZ_WORD, 2, 32'h0000abcd, 8'h2, 1'b0);
		arr(BASE + 24'h10, SRM_SZ_WORD, 1'b0, 1'b1, '0, 1'b1, 32'habcd);
		$display("soft reset done");
		results();
	end
endmodule
